// file: pkg/pldc_pkg.sv
/*
  package of the indicator and port function control registers:
  offsets, field positions, reset values, blink timing and carriers.
  assumes a 200 MHz core clock and a 5-bit management register address.
*/
package pldc_pkg;

  // ==========================================================
  // register offsets
  localparam logic [4:0] IDC_ADDR = 5'h18;
  localparam logic [4:0] PFC_ADDR = 5'h19;

  // ==========================================================
  // indicator_direct_control fields
  localparam int IDC_ACT_RX_BIT = 8;
  localparam int IDC_BLINK_LO = 6;
  localparam int IDC_SPD_OVR_BIT = 5;
  localparam int IDC_LNK_OVR_BIT = 4;
  localparam int IDC_ACT_OVR_BIT = 3;
  localparam int IDC_SPD_VAL_BIT = 2;
  localparam int IDC_LNK_VAL_BIT = 1;
  localparam int IDC_ACT_VAL_BIT = 0;
  localparam logic [8:0] IDC_RESET = 9'h000;

  // ==========================================================
  // port_function_control fields
  localparam int PFC_XOVER_EN_BIT = 15;
  localparam int PFC_FORCE_XOVER_BIT = 14;
  localparam int PFC_PAUSE_RX_BIT = 13;
  localparam int PFC_PAUSE_TX_BIT = 12;
  localparam int PFC_INJECT_BIT = 11;
  localparam int PFC_SEQ_SEL_BIT = 10;
  localparam int PFC_PASS_BIT = 9;
  localparam int PFC_RUN_BIT = 8;
  localparam logic PFC_FORCE_XOVER_RESET = 1'b0;
  localparam logic PFC_SEQ_SEL_RESET = 1'b0;
  localparam logic PFC_RUN_RESET = 1'b0;
  localparam logic PFC_PASS_RESET = 1'b0;

  // ==========================================================
  // pause advertisement pair: bit 0 symmetric, bit 1 asymmetric
  localparam int PAUSE_SYM_BIT = 0;
  localparam int PAUSE_ASM_BIT = 1;

  // ==========================================================
  // blink timing: base tick at twice the fastest blink rate
  localparam int CLK_HZ = 200_000_000;
  localparam int BLINK_FAST_HZ = 48;
  localparam int BLINK_TICK_CYCLES = CLK_HZ / (2 * BLINK_FAST_HZ);

  typedef enum logic [1:0] {
    PLDC_BLINK_6HZ = 2'b00,
    PLDC_BLINK_12HZ = 2'b01,
    PLDC_BLINK_24HZ = 2'b10,
    PLDC_BLINK_48HZ = 2'b11
  } pldc_blink_type;

  // ==========================================================
  // stored indicator control fields
  typedef struct packed {
    logic activity_source_rx_only;
    pldc_blink_type blink_rate_select;
    logic speed_override_enable;
    logic link_override_enable;
    logic activity_override_enable;
    logic forced_speed_value;
    logic forced_link_value;
    logic forced_activity_value;
  } pldc_indicator_type;

  // live status from the port core
  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic tx_activity;
    logic rx_activity;
    logic blink_on_activity;
  } pldc_status_type;

endpackage

// file: logic/pldc_regs.sv
/*
  indicator direct control and port function control registers with
  indicator drive, blink divider, pause resolution and self-test control.
  assumes the management engine decodes serial frames into one-cycle
  read and write strobes on clk; port status comes from core logic on clk;
  the crossover strap is a pin and is synchronised here.
*/
module pldc_regs #(
  parameter int BLINK_TICK = pldc_pkg::BLINK_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  input wire pldc_pkg::pldc_status_type port_status,
  input wire logic [1:0] local_pause_adv,
  input wire logic [1:0] partner_pause_adv,
  input wire logic hcd_full_duplex,
  input wire logic crossover_strap,
  input wire logic selftest_error,
  output logic speed_indicator_pin,
  output logic link_indicator_pin,
  output logic activity_collision_indicator_pin,
  output logic auto_crossover_enable,
  output logic force_crossover,
  output logic selftest_run,
  output logic selftest_sequence_select,
  output logic selftest_error_inject
);

  // ==========================================================
  // decode
  // register select, shared by the write strobes and the read mux
  function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] reg_addr);
    return (addr == reg_addr);
  endfunction

  wire logic idc_sel = addr_hit(mgmt_addr, pldc_pkg::IDC_ADDR);
  wire logic pfc_sel = addr_hit(mgmt_addr, pldc_pkg::PFC_ADDR);
  wire logic idc_wr = mgmt_wr && idc_sel;
  wire logic pfc_wr = mgmt_wr && pfc_sel;

  // ==========================================================
  // strap capture after reset release
  logic strap_meta_q;
  logic strap_sync_q;
  logic [1:0] strap_wait_q;

  // strap reaches the second flop two edges after release; keep loading
  // through the third edge so the synchronised level is what lands
  wire logic strap_load = (strap_wait_q != 2'h3);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_meta_q <= 1'b0;
      strap_sync_q <= 1'b0;
      strap_wait_q <= 2'h0;
    end else begin
      strap_meta_q <= crossover_strap;
      strap_sync_q <= strap_meta_q;
      if (strap_load) begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end
    end
  end

  // ==========================================================
  // indicator_direct_control
  pldc_pkg::pldc_indicator_type idc_q;
  wire pldc_pkg::pldc_indicator_type idc_d = pldc_pkg::pldc_indicator_type'(mgmt_wdata[8:0]);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idc_q <= pldc_pkg::pldc_indicator_type'(pldc_pkg::IDC_RESET);
    end else if (idc_wr) begin
      idc_q <= idc_d;
    end
  end

  // ==========================================================
  // port_function_control
  logic xover_en_q;
  logic force_xover_q;
  logic seq_sel_q;
  logic run_q;
  logic pass_q;
  logic inject_q;
  logic run_d;

  assign run_d = pfc_wr ? mgmt_wdata[pldc_pkg::PFC_RUN_BIT] : run_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xover_en_q <= 1'b0;
    end else if (strap_load) begin
      xover_en_q <= strap_sync_q;
    end else if (pfc_wr) begin
      xover_en_q <= mgmt_wdata[pldc_pkg::PFC_XOVER_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      force_xover_q <= pldc_pkg::PFC_FORCE_XOVER_RESET;
    end else if (pfc_wr) begin
      force_xover_q <= mgmt_wdata[pldc_pkg::PFC_FORCE_XOVER_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seq_sel_q <= pldc_pkg::PFC_SEQ_SEL_RESET;
    end else if (pfc_wr) begin
      seq_sel_q <= mgmt_wdata[pldc_pkg::PFC_SEQ_SEL_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_q <= pldc_pkg::PFC_RUN_RESET;
    end else if (pfc_wr) begin
      run_q <= run_d;
    end
  end

  // one-cycle inject pulse; the stored bit never reads back as one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inject_q <= 1'b0;
    end else begin
      inject_q <= pfc_wr && mgmt_wdata[pldc_pkg::PFC_INJECT_BIT] && run_d;
    end
  end

  // pass latch: set at start, dropped on any error after the start cycle, cleared on stop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pass_q <= pldc_pkg::PFC_PASS_RESET;
    end else if (!run_d) begin
      pass_q <= 1'b0;
    end else if (!run_q) begin
      pass_q <= 1'b1;
    end else if (selftest_error) begin
      pass_q <= 1'b0;
    end
  end

  // ==========================================================
  // pause resolution, full duplex only
  wire logic l_sym = local_pause_adv[pldc_pkg::PAUSE_SYM_BIT];
  wire logic l_asm = local_pause_adv[pldc_pkg::PAUSE_ASM_BIT];
  wire logic p_sym = partner_pause_adv[pldc_pkg::PAUSE_SYM_BIT];
  wire logic p_asm = partner_pause_adv[pldc_pkg::PAUSE_ASM_BIT];
  wire logic both_sym = l_sym && p_sym;
  wire logic pause_rx = hcd_full_duplex && (both_sym || (l_sym && l_asm && !p_sym && p_asm));
  wire logic pause_tx = hcd_full_duplex && (both_sym || (!l_sym && l_asm && p_sym && p_asm));

  // ==========================================================
  // blink divider
  logic [31:0] tick_cnt_q;
  logic [3:0] phase_q;
  wire logic tick = (tick_cnt_q == 32'(BLINK_TICK - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 32'h0000_0000;
      phase_q <= 4'h0;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
      phase_q <= phase_q + 4'h1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  logic blink_phase;
  always_comb begin
    case (idc_q.blink_rate_select)
      pldc_pkg::PLDC_BLINK_48HZ: blink_phase = phase_q[0];
      pldc_pkg::PLDC_BLINK_24HZ: blink_phase = phase_q[1];
      pldc_pkg::PLDC_BLINK_12HZ: blink_phase = phase_q[2];
      pldc_pkg::PLDC_BLINK_6HZ: blink_phase = phase_q[3];
      default: blink_phase = phase_q[3];
    endcase
  end

  // ==========================================================
  // indicator drive
  wire logic activity = idc_q.activity_source_rx_only ? port_status.rx_activity
                      : (port_status.rx_activity || port_status.tx_activity);
  wire logic link_normal = port_status.link_up
                         && !(port_status.blink_on_activity && activity && blink_phase);
  wire logic spd_d = idc_q.speed_override_enable ? idc_q.forced_speed_value
                   : port_status.speed_100;
  wire logic lnk_d = idc_q.link_override_enable ? idc_q.forced_link_value
                   : link_normal;
  wire logic act_d = idc_q.activity_override_enable ? idc_q.forced_activity_value
                   : activity;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      speed_indicator_pin <= 1'b0;
    end else begin
      speed_indicator_pin <= spd_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_indicator_pin <= 1'b0;
    end else begin
      link_indicator_pin <= lnk_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      activity_collision_indicator_pin <= 1'b0;
    end else begin
      activity_collision_indicator_pin <= act_d;
    end
  end

  // ==========================================================
  // read path
  wire logic [15:0] idc_rd = {7'h00, idc_q};
  wire logic [15:0] pfc_rd = {xover_en_q, force_xover_q, pause_rx, pause_tx, 1'b0,
                              seq_sel_q, pass_q, run_q, 8'h00};
  wire logic [15:0] rd_d = idc_sel ? idc_rd
                         : pfc_sel ? pfc_rd : 16'h0000;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mgmt_rdata <= 16'h0000;
    end else if (mgmt_rd) begin
      mgmt_rdata <= rd_d;
    end
  end

  // ==========================================================
  // control outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      auto_crossover_enable <= 1'b0;
    end else begin
      auto_crossover_enable <= xover_en_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      force_crossover <= 1'b0;
    end else begin
      force_crossover <= force_xover_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      selftest_run <= 1'b0;
    end else begin
      selftest_run <= run_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      selftest_sequence_select <= 1'b0;
    end else begin
      selftest_sequence_select <= seq_sel_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      selftest_error_inject <= 1'b0;
    end else begin
      selftest_error_inject <= inject_q;
    end
  end

endmodule // pldc_regs

// file: verification/pldc_regs_sva.sv
/*
  checker for the indicator and port function control registers.
  assumes the pldc_regs ports and the pldc_pkg constants.
*/
module pldc_regs_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic [1:0] local_pause_adv,
  input wire logic [1:0] partner_pause_adv,
  input wire logic hcd_full_duplex,
  input wire logic speed_indicator_pin,
  input wire logic link_indicator_pin,
  input wire logic activity_collision_indicator_pin,
  input wire logic selftest_run,
  input wire logic selftest_error_inject
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // decode
  wire idc_wr = mgmt_wr && (mgmt_addr == pldc_pkg::IDC_ADDR);
  wire pfc_wr = mgmt_wr && (mgmt_addr == pldc_pkg::PFC_ADDR);
  wire idc_rd = mgmt_rd && (mgmt_addr == pldc_pkg::IDC_ADDR);
  wire pfc_rd = mgmt_rd && (mgmt_addr == pldc_pkg::PFC_ADDR);
  wire [1:0] l = local_pause_adv;
  wire [1:0] p = partner_pause_adv;
  wire prx = hcd_full_duplex && (l[0] && p[0] || l[0] && l[1] && !p[0] && p[1]);
  wire ptx = hcd_full_duplex && (l[0] && p[0] || !l[0] && l[1] && p[0] && p[1]);
  sequence ovr_write(b);
    idc_wr && mgmt_wdata[b] ##1 !idc_wr;
  endsequence
  sequence run_write;
    pfc_wr ##1 !pfc_wr;
  endsequence
  // ==========================================================
  // properties
  spd_force_a: assert property (ovr_write(5) |=> speed_indicator_pin == $past(mgmt_wdata[2], 2))
    else $error("speed pin not forced");
  lnk_force_a: assert property (ovr_write(4) |=> link_indicator_pin == $past(mgmt_wdata[1], 2))
    else $error("link pin not forced");
  act_force_a: assert property (ovr_write(3) |=> activity_collision_indicator_pin == $past(mgmt_wdata[0], 2))
    else $error("activity pin not forced");
  rsvd_zero_a: assert property (idc_rd |=> mgmt_rdata[15:9] == 7'h00)
    else $error("reserved bits not zero");
  pause_rx_a: assert property (pfc_rd |=> mgmt_rdata[13] == $past(prx))
    else $error("pause receive wrong");
  pause_tx_a: assert property (pfc_rd |=> mgmt_rdata[12] == $past(ptx))
    else $error("pause transmit wrong");
  inject_pulse_a: assert property (pfc_wr && mgmt_wdata[11] && mgmt_wdata[8] |-> ##2 selftest_error_inject ##1 !selftest_error_inject)
    else $error("inject pulse wrong");
  inject_clear_a: assert property (pfc_rd |=> !mgmt_rdata[11])
    else $error("inject bit reads one");
  run_follow_a: assert property (run_write |=> selftest_run == $past(mgmt_wdata[8], 2))
    else $error("run output wrong");
endmodule // pldc_regs_sva

bind pldc_regs pldc_regs_sva u_sva (.clk, .resetn, .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata,
  .mgmt_rdata, .local_pause_adv, .partner_pause_adv, .hcd_full_duplex, .speed_indicator_pin,
  .link_indicator_pin, .activity_collision_indicator_pin, .selftest_run, .selftest_error_inject);

// file: verification/pldc_mgmt_model.sv
/*
  management controller model issuing one-cycle register strobes.
  assumes read data registered one cycle after the read strobe.
*/
module pldc_mgmt_model (
  input wire logic clk,
  output logic [4:0] mgmt_addr,
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // strobes
  initial begin
    mgmt_addr = 5'h00;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_wdata = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    mgmt_addr <= a;
    mgmt_wdata <= d;
    mgmt_wr <= 1'b1;
    @(posedge clk);
    mgmt_wr <= 1'b0;
    mgmt_addr <= ~a;
    mgmt_wdata <= ~d; // released bus shows no stale value
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    mgmt_addr <= a;
    mgmt_rd <= 1'b1;
    @(posedge clk);
    mgmt_rd <= 1'b0;
    mgmt_addr <= ~a;
    #1 d = mgmt_rdata;
  endtask
endmodule // pldc_mgmt_model

// file: verification/pldc_regs_tb_top.sv
/*
  testbench for the indicator and port function control registers.
  assumes pldc_pkg, pldc_regs, the checker and the management model.
*/
module pldc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] IA = pldc_pkg::IDC_ADDR;
  localparam logic [4:0] PA = pldc_pkg::PFC_ADDR;
  localparam int TICK = 4;
  logic clk, resetn, hcd, strap, st_err;
  logic [1:0] lpa, ppa;
  pldc_pkg::pldc_status_type st;
  wire logic [4:0] addr;
  wire logic wr, rd, spd, lnk, act, xen, xf, run, seq, inj;
  wire logic [15:0] wdata, rdata;
  int n_errors = 0;
  int num_checks = 0;
  int c;
  logic [15:0] d;
  logic rx, tx;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  pldc_mgmt_model MGMT (.clk(clk), .mgmt_addr(addr), .mgmt_wr(wr), .mgmt_rd(rd),
    .mgmt_wdata(wdata), .mgmt_rdata(rdata));
  pldc_regs #(.BLINK_TICK(TICK)) DUT (.clk(clk), .resetn(resetn), .mgmt_addr(addr),
    .mgmt_wr(wr), .mgmt_rd(rd), .mgmt_wdata(wdata), .mgmt_rdata(rdata), .port_status(st),
    .local_pause_adv(lpa), .partner_pause_adv(ppa), .hcd_full_duplex(hcd),
    .crossover_strap(strap), .selftest_error(st_err), .speed_indicator_pin(spd),
    .link_indicator_pin(lnk), .activity_collision_indicator_pin(act),
    .auto_crossover_enable(xen), .force_crossover(xf), .selftest_run(run),
    .selftest_sequence_select(seq), .selftest_error_inject(inj));
  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    MGMT.rd(a, d);
    chk(d, e);
  endtask
  task automatic outs(input logic [15:0] e);
    @(posedge clk);
    #1 chk({11'h000, spd, lnk, act, xen, xf}, e);
  endtask
  task automatic gap(output int n);
    logic p;
    #1 p = lnk;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (lnk === p && n < 300);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end
  // ==========================================================
  // tests
  initial begin
    resetn = 1'b0;
    {hcd, lpa, ppa, st_err, st} = '0;
    strap = 1'b1;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    rchk(IA, 16'h0000);
    rchk(PA, 16'h8000);
    rchk(5'h1a, 16'h0000);
    $display("test reset done");
    MGMT.wr(IA, 16'hffff);
    outs(16'h001e);
    rchk(IA, 16'h01ff);
    MGMT.wr(IA, 16'h0038);
    outs(16'h0002);
    st <= 5'b11000;
    MGMT.wr(IA, 16'h0000);
    outs(16'h001a);
    st <= 5'b00100;
    outs(16'h0006);
    MGMT.wr(IA, 16'h0100);
    outs(16'h0002);
    $display("test indicators done");
    st <= 5'b10011;
    for (int k = 0; k < 4; k++) begin
      MGMT.wr(IA, {8'h00, k[1:0], 6'h00});
      repeat (2) @(posedge clk);
      gap(c);
      gap(c);
      chk(c[15:0], 16'(TICK << (3 - k)));
    end
    st <= 5'b00000;
    $display("test blink done");
    for (int v = 0; v < 32; v++) begin
      {hcd, lpa, ppa} <= v[4:0];
      rx = v[4] && (v[2] && v[0] || v[2] && v[3] && !v[0] && v[1]);
      tx = v[4] && (v[2] && v[0] || !v[2] && v[3] && v[0] && v[1]);
      rchk(PA, {2'b10, rx, tx, 12'h000});
    end
    {hcd, lpa, ppa} <= 5'h00;
    $display("test pause done");
    MGMT.wr(PA, 16'h4000);
    outs(16'h0001);
    MGMT.wr(PA, 16'h8000);
    outs(16'h0002);
    MGMT.wr(PA, 16'h0500);
    @(posedge clk);
    #1 chk({14'h0000, run, seq}, 16'h0003);
    rchk(PA, 16'h0700);
    MGMT.wr(PA, 16'h0d00);
    @(posedge clk);
    #1 chk({15'h0000, inj}, 16'h0001);
    @(posedge clk);
    #1 chk({15'h0000, inj}, 16'h0000);
    rchk(PA, 16'h0700);
    @(posedge clk);
    st_err <= 1'b1;
    @(posedge clk);
    st_err <= 1'b0;
    rchk(PA, 16'h0500);
    MGMT.wr(PA, 16'h0400);
    rchk(PA, 16'h0400);
    MGMT.wr(PA, 16'h0100);
    rchk(PA, 16'h0300);
    $display("test selftest done");
    resetn <= 1'b0;
    strap <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    outs(16'h0000);
    rchk(PA, 16'h0000);
    rchk(IA, 16'h0000);
    $display("test strap reload done");
    wrap_up();
  end
endmodule // pldc_regs_tb_top
